// file: hdl/cpa_prom_access.sv
/*
 * Configuration PROM access unit: control/status, word address and data
 * registers, command execution through a serial engine or host emulation.
 * Assumes the serial engine, ownership and frame logic sit on i_sys_clk;
 * mode and address-size pins are asynchronous.
 */
`default_nettype none
module cpa_prom_access #(
    parameter logic READ_8B = 1'b1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register writes from both sides
    input wire cpa_pkg::cpa_wr_t i_fb_wr,
    input wire cpa_pkg::cpa_wr_t i_host_wr,
    // Ownership, frame and mode pins
    input wire logic i_host_owns,
    input wire logic i_frame_start,
    input wire logic i_emulation_pin,
    input wire logic i_two_byte_addr_pin,
    // Serial engine
    output logic o_eng_start,
    output logic [2:0] o_eng_cmd,
    output logic [31:0] o_eng_addr,
    output logic [15:0] o_eng_wdata,
    input wire logic i_eng_done,
    input wire logic i_eng_nack,
    input wire logic i_eng_cks_err,
    input wire logic [63:0] i_eng_rdata,
    // Register read-back
    output logic [15:0] o_ctrl_status,
    output logic [31:0] o_word_addr,
    output logic [63:0] o_data,
    // Event and reload targets
    output logic o_evt_prom,
    output cpa_pkg::cpa_reload_t o_reload,
    output logic o_reload_first_done
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    function automatic logic hit(input cpa_pkg::cpa_wr_t w, input logic [15:0] ofs);
        return w.en && (w.ofs == ofs);
    endfunction

    function automatic logic [31:0] used_addr(input logic [31:0] a, input logic emu, input logic alg);
        logic [31:0] m;
        m = '1;
        if (!emu)
        begin
            m = ~(32'hFFFFFFFF << (alg ? cpa_pkg::CPA_AW_LARGE : cpa_pkg::CPA_AW_SMALL));
        end
        return a & m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    cpa_pkg::cpa_state_t state_r;
    logic emu_q1, emu_q2, alg_q1, alg_q2;
    logic [2:0] cmd_r;
    logic wren_r, cks_r, load_r, erra_r, errw_r;
    logic [31:0] addr_r;
    logic [63:0] data_r;
    cpa_pkg::cpa_wr_t owner_wr;
    logic busy, wren_eff, ctrl_norm, addr_norm, data_norm;
    logic emu_ctrl, emu_data, cmd_take, valid, start, ack, fail;
    logic done_emu, done_eng, finish;
    logic [2:0] wcmd;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            emu_q1 <= 1'b0;
            emu_q2 <= 1'b0;
            alg_q1 <= 1'b0;
            alg_q2 <= 1'b0;
        end
        else
        begin
            emu_q1 <= i_emulation_pin;
            emu_q2 <= emu_q1;
            alg_q1 <= i_two_byte_addr_pin;
            alg_q2 <= alg_q1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write qualification
    always_comb
    begin
        owner_wr = i_host_owns ? i_host_wr : i_fb_wr;
        busy = (state_r != cpa_pkg::CPA_S_IDLE);
        wren_eff = wren_r || i_host_owns;
        ctrl_norm = !busy && hit(owner_wr, cpa_pkg::CPA_OFS_CTRL);
        addr_norm = !busy && hit(owner_wr, cpa_pkg::CPA_OFS_ADDR);
        data_norm = !busy && hit(owner_wr, cpa_pkg::CPA_OFS_DATA);
        emu_ctrl = (state_r == cpa_pkg::CPA_S_EMU) && hit(i_host_wr, cpa_pkg::CPA_OFS_CTRL);
        emu_data = (state_r == cpa_pkg::CPA_S_EMU) && (cmd_r != cpa_pkg::CPA_CMD_WRITE)
            && hit(i_host_wr, cpa_pkg::CPA_OFS_DATA);
        wcmd = owner_wr.data[cpa_pkg::CPA_CMD_HI:cpa_pkg::CPA_CMD_LO];
        cmd_take = ctrl_norm && !erra_r;
        valid = (wcmd == cpa_pkg::CPA_CMD_READ) || (wcmd == cpa_pkg::CPA_CMD_WRITE)
            || (wcmd == cpa_pkg::CPA_CMD_RELOAD);
        start = cmd_take && valid && !((wcmd == cpa_pkg::CPA_CMD_WRITE) && !wren_eff);
        ack = emu_ctrl && |(i_host_wr.data[cpa_pkg::CPA_CMD_HI:cpa_pkg::CPA_CMD_LO] & cmd_r);
        fail = emu_ctrl && i_host_wr.data[cpa_pkg::CPA_B_ERRA];
        done_emu = ack || fail;
        done_eng = (state_r == cpa_pkg::CPA_S_ENG) && i_eng_done;
        finish = done_emu || done_eng;
    end

    ////////////////////////////////////////////////////////////////////
    // Command sequencing
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            state_r <= cpa_pkg::CPA_S_IDLE;
        end
        else
        begin
            case (state_r)
                cpa_pkg::CPA_S_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= emu_q2 ? cpa_pkg::CPA_S_EMU : cpa_pkg::CPA_S_ENG;
                    end
                end
                cpa_pkg::CPA_S_ENG:
                begin
                    if (i_eng_done)
                    begin
                        state_r <= cpa_pkg::CPA_S_IDLE;
                    end
                end
                cpa_pkg::CPA_S_EMU:
                begin
                    if (done_emu)
                    begin
                        state_r <= cpa_pkg::CPA_S_IDLE;
                    end
                end
                default:
                begin
                    state_r <= cpa_pkg::CPA_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            cmd_r <= cpa_pkg::CPA_CMD_IDLE;
        end
        else if (start)
        begin
            cmd_r <= wcmd;
        end
        else if (finish)
        begin
            cmd_r <= cpa_pkg::CPA_CMD_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Error and status flags
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            erra_r <= 1'b0;
            errw_r <= 1'b0;
        end
        else
        begin
            if (fail || (done_eng && i_eng_nack) || (cmd_take && !valid && wcmd != cpa_pkg::CPA_CMD_IDLE))
            begin
                erra_r <= 1'b1;
            end
            else if (ctrl_norm && (wcmd == cpa_pkg::CPA_CMD_IDLE || cmd_take))
            begin
                erra_r <= 1'b0;
            end
            if (cmd_take && (wcmd == cpa_pkg::CPA_CMD_WRITE) && !wren_eff)
            begin
                errw_r <= 1'b1;
            end
            else if (ctrl_norm && (wcmd == cpa_pkg::CPA_CMD_IDLE || (cmd_take && valid)))
            begin
                errw_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            cks_r <= 1'b0;
            load_r <= 1'b0;
        end
        else if (start && wcmd == cpa_pkg::CPA_CMD_RELOAD)
        begin
            cks_r <= 1'b0;
            load_r <= 1'b1;
        end
        else if (finish && cmd_r == cpa_pkg::CPA_CMD_RELOAD)
        begin
            cks_r <= (ack && i_host_wr.data[cpa_pkg::CPA_B_CKS]) || (done_eng && i_eng_cks_err);
            load_r <= fail || (done_eng && (i_eng_nack || i_eng_cks_err))
                || (ack && i_host_wr.data[cpa_pkg::CPA_B_CKS]);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            wren_r <= 1'b0;
        end
        else if (ctrl_norm && !i_host_owns)
        begin
            wren_r <= i_fb_wr.data[cpa_pkg::CPA_B_WREN];
        end
        else if (i_frame_start)
        begin
            wren_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address and data registers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            addr_r <= '0;
        end
        else if (addr_norm)
        begin
            addr_r <= owner_wr.data[31:0];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            data_r <= '0;
        end
        else if (emu_data)
        begin
            data_r <= i_host_wr.data;
        end
        else if (data_norm)
        begin
            data_r[cpa_pkg::CPA_WR_BITS-1:0] <= owner_wr.data[cpa_pkg::CPA_WR_BITS-1:0];
        end
        else if (done_eng && cmd_r == cpa_pkg::CPA_CMD_READ && !i_eng_nack)
        begin
            data_r <= READ_8B ? i_eng_rdata : {32'h0, i_eng_rdata[cpa_pkg::CPA_RD4_BITS-1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Engine request and event
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_eng_start <= 1'b0;
            o_eng_cmd <= cpa_pkg::CPA_CMD_IDLE;
            o_eng_addr <= '0;
            o_eng_wdata <= '0;
        end
        else
        begin
            o_eng_start <= start && !emu_q2;
            if (start && !emu_q2)
            begin
                o_eng_cmd <= wcmd;
                o_eng_addr <= used_addr(addr_r, emu_q2, alg_q2);
                o_eng_wdata <= data_r[cpa_pkg::CPA_WR_BITS-1:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_evt_prom <= 1'b0;
        end
        else if (start && emu_q2)
        begin
            o_evt_prom <= 1'b1;
        end
        else if (done_emu)
        begin
            o_evt_prom <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-back registers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_ctrl_status <= '0;
            o_word_addr <= '0;
            o_data <= '0;
        end
        else
        begin
            o_ctrl_status <= '0;
            o_ctrl_status[cpa_pkg::CPA_B_WREN] <= wren_eff;
            o_ctrl_status[cpa_pkg::CPA_B_EMU] <= emu_q2;
            o_ctrl_status[cpa_pkg::CPA_B_RD8] <= READ_8B;
            o_ctrl_status[cpa_pkg::CPA_B_ALG] <= alg_q2;
            o_ctrl_status[cpa_pkg::CPA_CMD_HI:cpa_pkg::CPA_CMD_LO] <= cmd_r;
            o_ctrl_status[cpa_pkg::CPA_B_CKS] <= cks_r;
            o_ctrl_status[cpa_pkg::CPA_B_LOAD] <= load_r;
            o_ctrl_status[cpa_pkg::CPA_B_ERRA] <= erra_r;
            o_ctrl_status[cpa_pkg::CPA_B_ERRW] <= errw_r;
            o_ctrl_status[cpa_pkg::CPA_B_BUSY] <= busy;
            o_word_addr <= addr_r;
            o_data <= data_r;
        end
    end

    cpa_reload_dist u_reload (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_load(ack && !fail && cmd_r == cpa_pkg::CPA_CMD_RELOAD),
        .i_data(data_r[31:0]),
        .o_cfg(o_reload),
        .o_first_done(o_reload_first_done)
    );

    ////////////////////////////////////////////////////////////////////
    sequence s_emu_start;
        start && emu_q2 ##1 state_r == cpa_pkg::CPA_S_EMU;
    endsequence

    a_busy_report: assert property (o_ctrl_status[15] == $past(busy))
        else $error("busy bit does not follow state");
    a_addr_blocked: assert property (busy |=> $stable(addr_r))
        else $error("address changed while busy");
    a_emu_ack_done: assert property (ack |=> !busy && cmd_r == 3'h0)
        else $error("acknowledge did not end command");
    a_evt_raise: assert property (s_emu_start |-> o_evt_prom)
        else $error("event request not raised");
    a_evt_clear: assert property (done_emu |=> !o_evt_prom)
        else $error("event request not cleared");
    a_wren_sof: assert property (i_frame_start && !(ctrl_norm && !i_host_owns) |=> !wren_r)
        else $error("write enable survived frame start");
    a_err_clear: assert property (ctrl_norm && wcmd == cpa_pkg::CPA_CMD_IDLE |=> !erra_r && !errw_r)
        else $error("idle command did not clear errors");
    a_cmd_ignored: assert property (erra_r && !busy |=> !busy)
        else $error("command taken with error pending");
    a_addr_mask: assert property (o_eng_start && !$past(emu_q2) && !$past(alg_q2) |-> o_eng_addr[31:10] == 0)
        else $error("small memory address too wide");
    a_data_upper: assert property (data_norm |=> $stable(data_r[63:16]))
        else $error("upper data written outside emulation");
endmodule
`default_nettype wire

// file: hdl/cpa_pkg.sv
/*
 * Shared constants and types of the configuration PROM access unit.
 * Assumes every user reads them as cpa_pkg::name.
 */
`default_nettype none
package cpa_pkg;
    // Register offsets
    localparam logic [15:0] CPA_OFS_CTRL = 16'h0502;
    localparam logic [15:0] CPA_OFS_ADDR = 16'h0504;
    localparam logic [15:0] CPA_OFS_DATA = 16'h0508;
    // Control/status bit positions
    localparam int CPA_B_WREN = 0;
    localparam int CPA_B_EMU = 5;
    localparam int CPA_B_RD8 = 6;
    localparam int CPA_B_ALG = 7;
    localparam int CPA_CMD_LO = 8;
    localparam int CPA_CMD_HI = 10;
    localparam int CPA_B_CKS = 11;
    localparam int CPA_B_LOAD = 12;
    localparam int CPA_B_ERRA = 13;
    localparam int CPA_B_ERRW = 14;
    localparam int CPA_B_BUSY = 15;
    // Command codes
    localparam logic [2:0] CPA_CMD_IDLE = 3'h0;
    localparam logic [2:0] CPA_CMD_READ = 3'h1;
    localparam logic [2:0] CPA_CMD_WRITE = 3'h2;
    localparam logic [2:0] CPA_CMD_RELOAD = 3'h4;
    // Used address widths and data widths
    localparam int CPA_AW_SMALL = 10;
    localparam int CPA_AW_LARGE = 18;
    localparam int CPA_WR_BITS = 16;
    localparam int CPA_RD4_BITS = 32;
    // Reload layout
    localparam int CPA_RL_ELD_ALL = 16;
    localparam int CPA_RL_PORT_LO = 17;
    localparam int CPA_RL_DL_LO = 21;
    localparam int CPA_RL_FIFO_LO = 25;
    localparam logic [2:0] CPA_FIFO_MAX = 3'h7;
    // One register write from one side
    typedef struct packed {
        logic en;
        logic [15:0] ofs;
        logic [63:0] data;
    } cpa_wr_t;
    // Values distributed by a reload
    typedef struct packed {
        logic [15:0] station_alias;
        logic eld_all;
        logic [3:0] eld_port;
        logic [3:0] dl_cfg;
        logic [2:0] fifo_size;
    } cpa_reload_t;
    typedef enum logic [2:0] {
        CPA_S_IDLE = 3'b001,
        CPA_S_ENG = 3'b010,
        CPA_S_EMU = 3'b100
    } cpa_state_t;
endpackage
`default_nettype wire

// file: hdl/cpa_reload_dist.sv
/*
 * Distributes reload values to their target configuration fields.
 * Assumes i_load is a one-cycle pulse on the system clock.
 */
`default_nettype none
module cpa_reload_dist (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Reload request
    input wire logic i_load,
    input wire logic [31:0] i_data,
    // Targets
    output cpa_pkg::cpa_reload_t o_cfg,
    output logic o_first_done
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_cfg <= '0;
            o_first_done <= 1'b0;
        end
        else if (i_load)
        begin
            o_cfg.station_alias <= i_data[15:0];
            o_cfg.eld_all <= i_data[cpa_pkg::CPA_RL_ELD_ALL];
            o_cfg.eld_port <= i_data[cpa_pkg::CPA_RL_PORT_LO +: 4];
            o_first_done <= 1'b1;
            if (!o_first_done)
            begin
                o_cfg.dl_cfg <= i_data[cpa_pkg::CPA_RL_DL_LO +: 4];
                o_cfg.fifo_size <= cpa_pkg::CPA_FIFO_MAX - i_data[cpa_pkg::CPA_RL_FIFO_LO +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_dl_first_only: assert property (
        o_first_done |=> $stable(o_cfg.dl_cfg) && $stable(o_cfg.fifo_size))
        else $error("link config changed after first load");
    a_fifo_convert: assert property (
        i_load && !o_first_done
        |=> o_cfg.fifo_size + $past(i_data[cpa_pkg::CPA_RL_FIFO_LO +: 3]) == cpa_pkg::CPA_FIFO_MAX)
        else $error("fifo size not seven minus code");
endmodule
`default_nettype wire

// file: verif/cpa_engine_model.sv
/*
 * Behavioural model of the serial PROM engine on the far side of the unit.
 * Assumes the engine interface of cpa_prom_access on the same clock.
 */
`default_nettype none
module cpa_engine_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Command from the unit
    input wire logic i_start,
    input wire logic [2:0] i_cmd,
    input wire logic [31:0] i_addr,
    input wire logic [15:0] i_wdata,
    // Behaviour selection
    input wire logic i_slow,
    input wire logic i_fail,
    // Answer to the unit
    output logic o_done,
    output logic o_nack,
    output logic o_cks_err,
    output logic [63:0] o_rdata,
    // Observation
    output logic [31:0] o_seen_addr,
    output logic [2:0] o_seen_cmd,
    output logic [15:0] o_seen_wdata,
    output logic [7:0] o_starts
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_r;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            wait_r <= 8'h00;
            o_done <= 1'b0;
            o_nack <= 1'b0;
            o_cks_err <= 1'b0;
            o_rdata <= 64'h0123456789ABCDEF;
            o_starts <= 8'h00;
        end
        else
        begin
            o_done <= 1'b0;
            o_nack <= 1'b0;
            o_cks_err <= 1'b0;
            // Read data is only valid with done; otherwise it keeps moving
            o_rdata <= {o_rdata[62:0], ~o_rdata[63]};
            if (i_start)
            begin
                o_seen_addr <= i_addr;
                o_seen_cmd <= i_cmd;
                o_seen_wdata <= i_wdata;
                o_starts <= o_starts + 8'h01;
                wait_r <= i_slow ? 8'h28 : 8'h04;
            end
            else if (wait_r != 8'h00)
            begin
                wait_r <= wait_r - 8'h01;
                if (wait_r == 8'h01)
                begin
                    o_done <= 1'b1;
                    o_nack <= i_fail;
                    o_cks_err <= i_fail && (o_seen_cmd == cpa_pkg::CPA_CMD_RELOAD);
                    o_rdata <= {~o_seen_addr, o_seen_addr};
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/config_prom_access_emulation_tb.sv
/*
 * Self-checking testbench of the configuration PROM access unit.
 * Assumes the unit and the engine model above; inputs change on falling edges.
 */
`default_nettype none
module config_prom_access_emulation_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CT = cpa_pkg::CPA_OFS_CTRL;
    localparam logic [15:0] AD = cpa_pkg::CPA_OFS_ADDR;
    localparam logic [15:0] DT = cpa_pkg::CPA_OFS_DATA;
    logic i_sys_clk, i_rst, host_owns, frame_start, emu_pin, two_byte_pin, slow, fail;
    cpa_pkg::cpa_wr_t fb_wr, host_wr;
    logic eng_start, eng_done, eng_nack, eng_cks, evt, first_done;
    logic [2:0] eng_cmd, seen_cmd;
    logic [31:0] eng_addr, word_addr, seen_addr;
    logic [15:0] eng_wdata, ctrl_status, seen_wdata;
    logic [63:0] eng_rdata, data_rb;
    logic [7:0] starts, starts0;
    cpa_pkg::cpa_reload_t reload;
    int bad_count, compares;
    ////////////////////////////////////////////////////////////////////////
    cpa_prom_access #(.READ_8B(1'b1)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fb_wr(fb_wr), .i_host_wr(host_wr),
        .i_host_owns(host_owns), .i_frame_start(frame_start), .i_emulation_pin(emu_pin),
        .i_two_byte_addr_pin(two_byte_pin), .o_eng_start(eng_start), .o_eng_cmd(eng_cmd),
        .o_eng_addr(eng_addr), .o_eng_wdata(eng_wdata), .i_eng_done(eng_done), .i_eng_nack(eng_nack),
        .i_eng_cks_err(eng_cks), .i_eng_rdata(eng_rdata), .o_ctrl_status(ctrl_status),
        .o_word_addr(word_addr), .o_data(data_rb), .o_evt_prom(evt), .o_reload(reload),
        .o_reload_first_done(first_done));
    cpa_engine_model engine (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(eng_start), .i_cmd(eng_cmd), .i_addr(eng_addr),
        .i_wdata(eng_wdata), .i_slow(slow), .i_fail(fail), .o_done(eng_done), .o_nack(eng_nack),
        .o_cks_err(eng_cks), .o_rdata(eng_rdata), .o_seen_addr(seen_addr), .o_seen_cmd(seen_cmd),
        .o_seen_wdata(seen_wdata), .o_starts(starts));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One register write, then three edges for the readback to settle
    task automatic wr(input logic host, input logic [15:0] ofs, input logic [63:0] d);
        if (host)
            host_wr = '{1'b1, ofs, d};
        else
            fb_wr = '{1'b1, ofs, d};
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        fb_wr.en = 1'b0;
        host_wr.en = 1'b0;
        repeat (3) @(negedge i_sys_clk);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (ctrl_status[15] !== 1'b0 && n < 200)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 200)
            chk(64'h1, 64'h0);
        repeat (2) @(negedge i_sys_clk);
    endtask
    task automatic conclude();
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge i_sys_clk);
        bad_count++;
        conclude();
    end
    initial
    begin
        bad_count = 0;
        compares = 0;
        {i_rst, host_owns, frame_start, emu_pin, two_byte_pin, slow, fail} = 7'b1000000;
        fb_wr = '0;
        host_wr = '0;
        repeat (10) @(negedge i_sys_clk);
        i_rst = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk(ctrl_status, 16'h0040);
        // Normal mode, fieldbus side owns
        wr(0, AD, 64'hFFFFFFFF);
        chk(word_addr, 32'hFFFFFFFF);
        wr(0, CT, 16'h0100);
        chk(ctrl_status, 16'h8140);
        wr(0, AD, 64'h0);
        wait_idle();
        chk(seen_addr, 32'h000003FF);
        chk(word_addr, 32'hFFFFFFFF);
        chk(data_rb, 64'hFFFFFC00000003FF);
        chk(ctrl_status, 16'h0040);
        wr(1, AD, 64'h12);
        chk(word_addr, 32'hFFFFFFFF);
        // Error bits and refused commands
        wr(0, CT, 16'h0200);
        chk(ctrl_status, 16'h4040);
        wr(0, CT, 16'h0000);
        chk(ctrl_status, 16'h0040);
        wr(0, CT, 16'h0300);
        chk(ctrl_status, 16'h2040);
        starts0 = starts;
        wr(0, CT, 16'h0100);
        chk(ctrl_status, 16'h2040);
        chk(starts, starts0);
        wr(0, CT, 16'h0000);
        chk(ctrl_status, 16'h0040);
        // Write command with write enable, then frame start
        wr(0, CT, 16'h0001);
        wr(0, DT, 64'hFFFFFFFFFFFFBEEF);
        chk(data_rb, 64'hFFFFFC000000BEEF);
        wr(0, CT, 16'h0201);
        wait_idle();
        chk({seen_cmd, seen_wdata}, {3'h2, 16'hBEEF});
        chk(ctrl_status, 16'h0041);
        frame_start = 1'b1;
        @(negedge i_sys_clk);
        frame_start = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk(ctrl_status, 16'h0040);
        // Large memory, slow engine, then a missing acknowledge
        two_byte_pin = 1'b1;
        slow = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        wr(0, CT, 16'h0100);
        wait_idle();
        chk(seen_addr, 32'h0003FFFF);
        chk(data_rb, 64'hFFFC00000003FFFF);
        fail = 1'b1;
        wr(0, CT, 16'h0100);
        wait_idle();
        chk(ctrl_status, 16'h20C0);
        wr(0, CT, 16'h0000);
        {fail, slow, two_byte_pin} = 3'b000;
        // Emulation: host stands in for the memory
        emu_pin = 1'b1;
        host_owns = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk(ctrl_status, 16'h0061);
        starts0 = starts;
        wr(1, AD, 64'hFFFFFFFF);
        wr(1, CT, 16'h0100);
        chk({evt, ctrl_status}, {1'b1, 16'h8161});
        wr(0, AD, 64'h0);
        wr(1, DT, 64'h1122334455667788);
        chk(data_rb, 64'h1122334455667788);
        wr(1, CT, 16'h0100);
        chk({evt, ctrl_status}, {1'b0, 16'h0061});
        chk(word_addr, 32'hFFFFFFFF);
        chk(starts, starts0);
        // Two reloads: link config and fifo size only take the first
        wr(1, CT, 16'h0400);
        chk(ctrl_status, 16'h9461);
        wr(1, DT, 64'h04B5A55A);
        wr(1, CT, 16'h0400);
        chk(64'(reload), {36'h0, 16'hA55A, 1'b1, 4'hA, 4'h5, 3'h5});
        chk({first_done, ctrl_status}, {1'b1, 16'h0061});
        wr(1, CT, 16'h0400);
        wr(1, DT, 64'h0E6A1234);
        wr(1, CT, 16'h0400);
        chk(64'(reload), {36'h0, 16'h1234, 1'b0, 4'h5, 4'h5, 3'h5});
        // Host signals a temporary failure, then a checksum failure
        wr(1, CT, 16'h0100);
        wr(1, CT, 16'h2000);
        chk(ctrl_status, 16'h2061);
        wr(1, CT, 16'h0000);
        chk(ctrl_status, 16'h0061);
        wr(1, CT, 16'h0400);
        wr(1, CT, 16'h0C00);
        chk({ctrl_status[15], ctrl_status[12:11]}, 3'b011);
        conclude();
    end
endmodule
`default_nettype wire
